// ---- src/irr_top.sv ----
// request register bank and extended node routing
//
// Local design decision: the strobed register port.
`include "irr_defines.svh"
module irr_top
  import irr_pkg::*;
(
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic rst_n, // synchronous reset, low active
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic [2:0] ext_pin_a, // default pins of requests 0..2
  input wire logic [2:0] ext_pin_b, // alternate pins of requests 0..2
  input wire logic [3:0] ext_pin_hi, // pins of requests 3..6
  input wire logic [2:0] serial_evt, // error, transmit, receive pulses
  input wire logic [1:0] conv_evt, // converter service pulses
  input wire logic [3:0] bus_ctl_evt, // bus controller 0..3 pulses
  input wire logic ssc_req, // synchronous serial request level
  input wire logic [5:0] node8_req, // timer, rotation, uart, divider, mdu levels
  input wire logic [3:0] capcomp_ptr, // capture pointers 0..3
  input wire logic [3:0] bus_ctl_node_hi, // bus controller nodes 4..7
  output logic map_select, // alternate register map active
  output logic idle_mode, // idle request bit
  output logic [2:0] page, // current page
  output logic [1:0] async_rx_input_sel, // serial receive source select
  output logic test_clock_input_sel, // test clock source select
  output logic test_data_input_sel, // test data source select
  output logic [6:0] nmi_enable, // non-maskable source enables
  output logic [7:0] node_req, // node 6..13 requests
  output logic [15:0] vector_addr, // vector of lowest-numbered node requesting
  output logic vector_valid, // a node is requesting
  output logic irq // masked sticky node interrupt
);
  irr_state_t q;
  irr_state_t d;
  logic [6:0] ext_evt;
  logic [6:0] pin_mux;
  logic [7:0] node_raw;
  logic scu_vis;
  logic pg0;

  // vector address of node 6+k
  function automatic logic [15:0] node_vec(input logic [2:0] k);
    node_vec = `IRR_VEC_BASE + (`IRR_VEC_STEP * {13'h0000, k});
  endfunction

  // pick source of requests 0..2 before synchronising
  assign pin_mux[0] = q.pisel[1] ? ext_pin_b[0] : ext_pin_a[0];
  assign pin_mux[1] = q.pisel[2] ? ext_pin_b[1] : ext_pin_a[1];
  assign pin_mux[2] = q.pisel[3] ? ext_pin_b[2] : ext_pin_a[2];
  assign pin_mux[6:3] = ext_pin_hi;

  irr_edge_det u_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_raw(pin_mux),
    .trig({q.exi1, q.exi0}),
    .evt(ext_evt)
  );

  // access windows of the register map
  assign scu_vis = ~q.map_sel;
  assign pg0 = scu_vis && (q.page == 3'h0);

  // node request terms from pending flags and peripheral levels
  always_comb
  begin
    node_raw[0] = q.node_en[0] & (|q.req1[6:3]);
    node_raw[1] = q.node_en[1] & ssc_req;
    node_raw[2] = q.node_en[2] & (q.req0[2] | (|node8_req));
    node_raw[3] = q.node_en[3] & ((|q.req0[6:3]) | q.req2[1]);
    for (int k = 0; k < 4; k++)
    begin
      node_raw[4+k] = q.node_en[4+k] & (capcomp_ptr[k] | bus_ctl_node_hi[k]);
    end
  end

  // next state: bus decode, flag update, routing
  always_comb
  begin
    d = q;
    d.rdata = 8'h00;
    // read path, answered in the following cycle
    if (reg_rd)
    begin
      if (reg_addr == `IRR_ADDR_SYS0)
        d.rdata = {3'b000, q.idle_mode, 3'b010, q.map_sel};
      else if (scu_vis && reg_addr == `IRR_ADDR_PAGE)
        d.rdata = {5'b00000, q.page};
      else if (pg0)
      begin
        case (reg_addr)
          `IRR_ADDR_PISEL: d.rdata = {1'b0, q.pisel};
          `IRR_ADDR_REQ0: d.rdata = {1'b0, q.req0};
          `IRR_ADDR_REQ1: d.rdata = {1'b0, q.req1};
          `IRR_ADDR_REQ2: d.rdata = {3'b000, q.req2[1], 3'b000, q.req2[0]};
          `IRR_ADDR_EXI0: d.rdata = q.exi0;
          `IRR_ADDR_EXI1: d.rdata = {2'b00, q.exi1};
          `IRR_ADDR_NMI: d.rdata = {1'b0, q.nmi};
          `IRR_ADDR_NODE_EN: d.rdata = q.node_en;
          `IRR_ADDR_NODE_STAT: d.rdata = q.node_stat;
          `IRR_ADDR_NODE_MASK: d.rdata = q.node_mask;
          default: d.rdata = 8'h00;
        endcase
      end
    end
    // write path
    if (reg_wr)
    begin
      if (reg_addr == `IRR_ADDR_SYS0)
      begin
        d.map_sel = reg_wdata[`IRR_SYS0_MAP_BIT];
        d.idle_mode = reg_wdata[`IRR_SYS0_IDLE_BIT];
      end
      else if (scu_vis && reg_addr == `IRR_ADDR_PAGE)
      begin
        // operation and slot fields act once and are not stored
        case (irr_pageop_t'(reg_wdata[`IRR_PAGE_OP_MSB:`IRR_PAGE_OP_LSB]))
          IRR_OP_STORE:
          begin
            d.slots[reg_wdata[`IRR_PAGE_SLOT_MSB:`IRR_PAGE_SLOT_LSB]] = q.page;
            d.page = reg_wdata[2:0];
          end
          IRR_OP_RESTORE: d.page =
            q.slots[reg_wdata[`IRR_PAGE_SLOT_MSB:`IRR_PAGE_SLOT_LSB]];
          default: d.page = reg_wdata[2:0];
        endcase
      end
      else if (pg0)
      begin
        case (reg_addr)
          `IRR_ADDR_PISEL: d.pisel = reg_wdata[6:0];
          `IRR_ADDR_REQ0: d.req0 = reg_wdata[6:0];
          `IRR_ADDR_REQ1: d.req1 = reg_wdata[6:0];
          `IRR_ADDR_REQ2: d.req2 = {reg_wdata[`IRR_REQ2_HI_BIT], reg_wdata[0]};
          `IRR_ADDR_EXI0: d.exi0 = reg_wdata;
          `IRR_ADDR_EXI1: d.exi1 = reg_wdata[5:0];
          `IRR_ADDR_NMI: d.nmi = reg_wdata[6:0];
          `IRR_ADDR_NODE_EN: d.node_en = reg_wdata;
          `IRR_ADDR_NODE_STAT: d.node_stat = q.node_stat & ~reg_wdata;
          `IRR_ADDR_NODE_MASK: d.node_mask = reg_wdata;
          default: d.rdata = d.rdata;
        endcase
      end
    end
    // hardware sets win over a software write in the same cycle
    d.req0 = d.req0 | ext_evt;
    d.req1 = d.req1 | {bus_ctl_evt[2:1], conv_evt, serial_evt};
    d.req2 = d.req2 | {bus_ctl_evt[3], bus_ctl_evt[0]};
    // node requests and sticky status, set beats write-one-clear
    d.node_req = node_raw;
    d.node_stat = d.node_stat | node_raw;
    d.irq = |(d.node_stat & d.node_mask);
    // lowest node number has priority for the vector
    d.vec_valid = |node_raw;
    d.vec = 16'h0000;
    for (int k = `IRR_NUM_NODES - 1; k >= 0; k--)
    begin
      if (node_raw[k])
        d.vec = node_vec(3'(k));
    end
  end

  // register state, synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.exi0 <= `IRR_RST_EXI0;
      q.exi1 <= `IRR_RST_EXI1;
    end
    else
      q <= d;
  end

  // outputs straight from the state register
  assign reg_rdata = q.rdata;
  assign map_select = q.map_sel;
  assign idle_mode = q.idle_mode;
  assign page = q.page;
  assign async_rx_input_sel = {q.pisel[6], q.pisel[0]};
  assign test_clock_input_sel = q.pisel[4];
  assign test_data_input_sel = q.pisel[5];
  assign nmi_enable = q.nmi;
  assign node_req = q.node_req;
  assign vector_addr = q.vec;
  assign vector_valid = q.vec_valid;
  assign irq = q.irq;

  // checks on the routing behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd_req(logic [7:0] a);
    reg_rd && reg_addr == a && !q.map_sel && q.page == 3'h0;
  endsequence

  AST_SYS0_READ: assert property (
    reg_rd && reg_addr == `IRR_ADDR_SYS0 |=> reg_rdata[2] && reg_rdata[0] == map_select
      && reg_rdata[7:5] == 3'b000)
    else $error("system control read wrong");

  AST_MAP_HIDES: assert property (
    reg_rd && reg_addr == `IRR_ADDR_REQ0 && q.map_sel |=> reg_rdata == 8'h00)
    else $error("request register visible in alternate map");

  AST_REQ0_SETWIN: assert property (
    ext_evt[0] && reg_wr && reg_addr == `IRR_ADDR_REQ0 && pg0 |=> q.req0[0])
    else $error("pin event lost against write");

  AST_REQ0_READ: assert property (
    s_rd_req(`IRR_ADDR_REQ0) |=> reg_rdata == {1'b0, $past(q.req0)})
    else $error("request register 0 read wrong");

  AST_REQ2_ZERO: assert property (
    s_rd_req(`IRR_ADDR_REQ2) |=> (reg_rdata & 8'hee) == 8'h00)
    else $error("request register 2 unused bits set");

  AST_EXI1_ZERO: assert property (
    s_rd_req(`IRR_ADDR_EXI1) |=> reg_rdata[7:6] == 2'b00)
    else $error("trigger register 1 top bits set");

  AST_PAGE_WO: assert property (
    reg_rd && reg_addr == `IRR_ADDR_PAGE && !q.map_sel |=> reg_rdata[7:3] == 5'b00000)
    else $error("page write-only fields readable");

  AST_RESET_VAL: assert property (
    $rose(rst_n) |-> q.exi0 == `IRR_RST_EXI0 && q.exi1 == `IRR_RST_EXI1 && q.nmi == 7'h00)
    else $error("trigger reset values wrong");

  AST_NMI_WRITE: assert property (
    reg_wr && reg_addr == `IRR_ADDR_NMI && pg0 ##1 s_rd_req(`IRR_ADDR_NMI)
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7f))
    else $error("nmi enable write not kept");

  AST_NODE6: assert property (
    q.node_en[0] && (|q.req1[6:3]) |=> node_req[0] && vector_valid
      && vector_addr == 16'h0033)
    else $error("node 6 not requested");

  AST_NODE9: assert property (
    q.node_en[3] && q.req2[1] |=> node_req[3])
    else $error("node 9 not requested");

  AST_NODE13_VEC: assert property (
    node_raw == 8'h80 |=> vector_addr == 16'h006b)
    else $error("node 13 vector wrong");

  AST_NODE7_GATE: assert property (
    !q.node_en[1] |=> !node_req[1])
    else $error("node 7 requested while disabled");
endmodule

// ---- inc/irr_defines.svh ----
// register offsets, field positions, reset values of the request routing block
`ifndef IRR_DEFINES_SVH
`define IRR_DEFINES_SVH
`define IRR_ADDR_SYS0 8'h8f
`define IRR_ADDR_PISEL 8'hb3
`define IRR_ADDR_REQ0 8'hb4
`define IRR_ADDR_REQ1 8'hb5
`define IRR_ADDR_REQ2 8'hb6
`define IRR_ADDR_EXI0 8'hb7
`define IRR_ADDR_EXI1 8'hba
`define IRR_ADDR_NMI 8'hbb
`define IRR_ADDR_NODE_EN 8'hbc
`define IRR_ADDR_NODE_STAT 8'hbd
`define IRR_ADDR_NODE_MASK 8'hbe
`define IRR_ADDR_PAGE 8'hbf
`define IRR_RST_EXI0 8'hf0
`define IRR_RST_EXI1 6'h3f
`define IRR_SYS0_MAP_BIT 0
`define IRR_SYS0_IDLE_BIT 4
`define IRR_SYS0_ONE_BIT 2
`define IRR_PAGE_OP_MSB 7
`define IRR_PAGE_OP_LSB 6
`define IRR_PAGE_SLOT_MSB 5
`define IRR_PAGE_SLOT_LSB 4
`define IRR_REQ2_HI_BIT 4
`define IRR_VEC_BASE 16'h0033
`define IRR_VEC_STEP 16'h0008
`define IRR_NUM_EXT 7
`define IRR_NUM_NODES 8
`endif

// ---- inc/irr_pkg.sv ----
// types of the request routing block
package irr_pkg;
  // trigger condition of one external request pin
  typedef enum logic [1:0] {
    IRR_TRIG_FALL = 2'b00,
    IRR_TRIG_RISE = 2'b01,
    IRR_TRIG_BOTH = 2'b10,
    IRR_TRIG_OFF = 2'b11
  } irr_trig_t;

  // page register operation field
  typedef enum logic [1:0] {
    IRR_OP_SET0 = 2'b00,
    IRR_OP_SET1 = 2'b01,
    IRR_OP_STORE = 2'b10,
    IRR_OP_RESTORE = 2'b11
  } irr_pageop_t;

  // state of the pin edge detector
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] prev;
  } irr_edge_state_t;

  // software register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } irr_bus_t;

  // state of the routing block outside the pin edge detector
  typedef struct packed {
    logic map_sel;
    logic idle_mode;
    logic [2:0] page;
    logic [3:0][2:0] slots;
    logic [6:0] pisel;
    logic [6:0] req0;
    logic [6:0] req1;
    logic [1:0] req2;
    logic [7:0] exi0;
    logic [5:0] exi1;
    logic [6:0] nmi;
    logic [7:0] node_en;
    logic [7:0] node_stat;
    logic [7:0] node_mask;
    logic [7:0] node_req;
    logic [15:0] vec;
    logic vec_valid;
    logic irq;
    logic [7:0] rdata;
  } irr_state_t;
endpackage

// ---- src/irr_edge_det.sv ----
// synchroniser and trigger detector for the external request pins
`include "irr_defines.svh"
module irr_edge_det
  import irr_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, low active
  input wire logic [6:0] pin_raw, // asynchronous request pins
  input wire logic [13:0] trig, // two bits of trigger mode per pin
  output logic [6:0] evt // one-cycle trigger pulses
);
  irr_edge_state_t q;
  irr_edge_state_t d;

  // two flops per pin, then one more for edge history
  always_comb
  begin
    d = q;
    d.sync1 = pin_raw;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
  end

  // decode trigger mode against last two settled samples
  always_comb
  begin
    for (int i = 0; i < `IRR_NUM_EXT; i++)
    begin
      case (irr_trig_t'(trig[2*i +: 2]))
        IRR_TRIG_FALL: evt[i] = q.prev[i] & ~q.sync2[i];
        IRR_TRIG_RISE: evt[i] = ~q.prev[i] & q.sync2[i];
        IRR_TRIG_BOTH: evt[i] = q.prev[i] ^ q.sync2[i];
        default: evt[i] = 1'b0;
      endcase
    end
  end

  // register state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      q <= '1; // history starts idle high, so no false edge follows reset
    else
      q <= d;
  end
endmodule

// ---- verif/irr_periph_model.sv ----
// peripheral side model raising pulse and level requests
module irr_periph_model (
  input wire logic clk_sys, // system clock
  output logic [2:0] serial_evt, // serial pulses
  output logic [1:0] conv_evt, // converter pulses
  output logic [3:0] bus_ctl_evt, // bus controller pulses
  output logic ssc_req, // sync serial level
  output logic [5:0] node8_req, // node 8 levels
  output logic [3:0] capcomp_ptr, // capture pointer levels
  output logic [3:0] bus_ctl_node_hi // bus controller node levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet at time zero
  initial
  begin
    serial_evt = 3'h0;
    conv_evt = 2'h0;
    bus_ctl_evt = 4'h0;
    levels_now(1'b0);
  end
  // pulses last one cycle, as a peripheral strobes them
  task automatic fire(input logic [2:0] s, input logic [1:0] c, input logic [3:0] b);
    @(posedge clk_sys);
    serial_evt <= s;
    conv_evt <= c;
    bus_ctl_evt <= b;
    @(posedge clk_sys);
    serial_evt <= 3'h0;
    conv_evt <= 2'h0;
    bus_ctl_evt <= 4'h0;
  endtask
  // level requests stay until serviced
  task automatic levels_now(input logic on);
    ssc_req <= on;
    node8_req <= {6{on}};
    capcomp_ptr <= {4{on}};
    bus_ctl_node_hi <= {4{on}};
  endtask
  task automatic levels(input logic on);
    @(posedge clk_sys);
    levels_now(on);
  endtask
endmodule

// ---- verif/testbench.sv ----
// register, pin and node routing tests of the request block
module testbench;
  import irr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] ext_pin_a = 3'h7;
  logic [2:0] ext_pin_b = 3'h7;
  logic [3:0] ext_pin_hi = 4'hf;
  logic [2:0] serial_evt;
  logic [1:0] conv_evt;
  logic [3:0] bus_ctl_evt;
  logic ssc_req;
  logic [5:0] node8_req;
  logic [3:0] capcomp_ptr;
  logic [3:0] bus_ctl_node_hi;
  logic [7:0] reg_rdata;
  logic map_select;
  logic idle_mode;
  logic [2:0] page;
  logic [1:0] async_rx_input_sel;
  logic test_clock_input_sel;
  logic test_data_input_sel;
  logic [6:0] nmi_enable;
  logic [7:0] node_req;
  logic [15:0] vector_addr;
  logic vector_valid;
  logic irq;
  int errors = 0;
  int tests_run = 0;
  logic [7:0] ra [9] = '{8'h8f, 8'hbf, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hba, 8'hbb};
  logic [7:0] rv [9] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf0, 8'h3f, 8'h00};

  always #5 clk_sys = ~clk_sys;

  irr_periph_model peri (.clk_sys(clk_sys), .serial_evt(serial_evt), .conv_evt(conv_evt),
    .bus_ctl_evt(bus_ctl_evt), .ssc_req(ssc_req), .node8_req(node8_req),
    .capcomp_ptr(capcomp_ptr), .bus_ctl_node_hi(bus_ctl_node_hi));

  irr_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin_a(ext_pin_a),
    .ext_pin_b(ext_pin_b), .ext_pin_hi(ext_pin_hi), .serial_evt(serial_evt),
    .conv_evt(conv_evt), .bus_ctl_evt(bus_ctl_evt), .ssc_req(ssc_req),
    .node8_req(node8_req), .capcomp_ptr(capcomp_ptr), .bus_ctl_node_hi(bus_ctl_node_hi),
    .map_select(map_select), .idle_mode(idle_mode), .page(page),
    .async_rx_input_sel(async_rx_input_sel), .test_clock_input_sel(test_clock_input_sel),
    .test_data_input_sel(test_data_input_sel), .nmi_enable(nmi_enable),
    .node_req(node_req), .vector_addr(vector_addr), .vector_valid(vector_valid), .irq(irq));

  // compare one value, count it, report a mismatch
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask
  // one write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  // one read cycle, data taken in the following cycle
  task automatic rdm(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
  endtask
  // let settled outputs be seen
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    close_out();
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values
    for (int i = 0; i < 9; i++)
      rdm(ra[i], rv[i]);
    wr(8'hbb, 8'hff);
    rdm(8'hbb, 8'h7f);
    chk("nmi_enable", 16'h007f, {9'h000, nmi_enable});
    wr(8'hba, 8'hff);
    rdm(8'hba, 8'h3f);
    $display("test registers done");
    // peripheral and software flags
    peri.fire(3'h7, 2'h3, 4'hf);
    rdm(8'hb5, 8'h7f);
    rdm(8'hb6, 8'h11);
    wr(8'hb4, 8'hff);
    rdm(8'hb4, 8'h7f);
    wr(8'hb4, 8'h00);
    rdm(8'hb4, 8'h00);
    $display("test flags done");
    // pin trigger and input select
    ext_pin_a[0] <= 1'b0;
    settle(6);
    rdm(8'hb4, 8'h01);
    wr(8'hb4, 8'h00);
    wr(8'hb3, 8'h73);
    rdm(8'hb3, 8'h73);
    chk("sel", 16'h000f, {12'h000, async_rx_input_sel, test_clock_input_sel,
      test_data_input_sel});
    ext_pin_a[0] <= 1'b1;
    settle(6);
    ext_pin_a[0] <= 1'b0;
    settle(6);
    rdm(8'hb4, 8'h00);
    ext_pin_b[0] <= 1'b0;
    settle(6);
    rdm(8'hb4, 8'h01);
    $display("test pins done");
    // map select and paging
    wr(8'hb4, 8'h7f);
    wr(8'h8f, 8'h11);
    chk("map_select", 16'h0001, {15'h0000, map_select});
    chk("idle_mode", 16'h0001, {15'h0000, idle_mode});
    rdm(8'hb4, 8'h00);
    rdm(8'h8f, 8'h15);
    wr(8'hb4, 8'h00);
    wr(8'h8f, 8'h00);
    rdm(8'hb4, 8'h7f);
    wr(8'hbf, 8'h01);
    rdm(8'hb3, 8'h00);
    rdm(8'hbf, 8'h01);
    wr(8'hbf, 8'ha2);
    rdm(8'hbf, 8'h02);
    wr(8'hbf, 8'he0);
    chk("page", 16'h0001, {13'h0000, page});
    wr(8'hbf, 8'h00);
    rdm(8'hb3, 8'h73);
    $display("test paging done");
    // node routing, one enable at a time
    peri.fire(3'h0, 2'h1, 4'h8);
    peri.levels(1'b1);
    for (int k = 0; k < 8; k++)
    begin
      wr(8'hbc, 8'h01 << k);
      settle(2);
      chk("node_req", 16'h0001 << k, {8'h00, node_req});
      chk("vector", 16'h0033 + 16'h0008 * k, vector_addr);
      chk("vector_valid", 16'h0001, {15'h0000, vector_valid});
    end
    // sticky status, mask and clear
    wr(8'hbe, 8'hff);
    settle(2);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(8'hbe, 8'h00);
    settle(2);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(8'hbc, 8'h00);
    settle(2);
    chk("node_req", 16'h0000, {8'h00, node_req});
    chk("vector_valid", 16'h0000, {15'h0000, vector_valid});
    chk("vector", 16'h0000, vector_addr);
    peri.levels(1'b0);
    wr(8'hb4, 8'h00);
    wr(8'hb5, 8'h00);
    wr(8'hb6, 8'h00);
    wr(8'hbd, 8'hff);
    rdm(8'hbd, 8'h00);
    wr(8'hbe, 8'hff);
    settle(2);
    chk("irq", 16'h0000, {15'h0000, irq});
    $display("test nodes done");
    close_out();
  end
endmodule
